// ==== ocpc_ctrl.sv ====
/*
 * ocpc_ctrl: clock distribution, ownership gating and always-on power control.
 * Assumes firmware config arrives as plain same-clock inputs, host-side enables
 * come from each peripheral's own register space, and wake pins are asynchronous.
 */
// Behaviour
// - pll at 6 GHz, post divide to four clocks
// - pll fed from 38.4 MHz crystal, own rail
// - route 125/500/400/200 MHz to their users
// - firmware-started pll power-up sequence
// - subsystem-owned: gate enable from local config
// - host-owned: gate enable from peripheral space
// - unowned peripheral always clock gated
// - soft reset source follows ownership too
// - ownership exclusive: subsystem or host only
// - always-on clock-gate machine with synchronisers
// - wake inputs filtered then recorded
// - sram machine keeps srams on in light idle
// - 32 kB banks, gated each in deepest idle
// - gated-side machine with wake, filter, sync
`timescale 1ns/1ns

module ocpc_ctrl (
	// clock and reset
	input  wire logic                               sys_clk,
	input  wire logic                               rstn,
	// pll control and status
	input  wire logic                               pllStart,
	input  wire logic                               pllLockPin,
	output logic                                    pllSupplyEn,
	output logic                                    pllEnable,
	output logic [7:0]                              pllMult,
	output logic                                    pllReady,
	// divided clock enables
	output logic                                    coreTick,
	output logic                                    dllTick,
	output logic                                    timerTick,
	output logic                                    ethTick,
	// per-peripheral ownership and enables
	input  wire logic [3*ocpc_pkg::NUM_PERIPH-1:0]  ownership,
	input  wire logic [ocpc_pkg::NUM_PERIPH-1:0]    localClkEn,
	input  wire logic [ocpc_pkg::NUM_PERIPH-1:0]    hostClkEn,
	input  wire logic [ocpc_pkg::NUM_PERIPH-1:0]    localRstEn,
	input  wire logic [ocpc_pkg::NUM_PERIPH-1:0]    hostRstEn,
	output logic [ocpc_pkg::NUM_PERIPH-1:0]         periphClkOn,
	output logic [ocpc_pkg::NUM_PERIPH-1:0]         periphTick,
	output logic [ocpc_pkg::NUM_PERIPH-1:0]         periphRst,
	// power state and wakes
	input  wire logic [1:0]                         powerState,
	input  wire logic                               idleReq,
	input  wire logic [ocpc_pkg::NUM_WAKE-1:0]      wakePin,
	input  wire logic [ocpc_pkg::NUM_WAKE-1:0]      wakeClear,
	output logic [ocpc_pkg::NUM_WAKE-1:0]           wakeRecord,
	output logic                                    funcClkOn,
	output logic                                    aonClkOn,
	output logic [ocpc_pkg::SRAM_BANKS-1:0]         sramBankOn,
	input  wire logic [ocpc_pkg::SRAM_BANKS-1:0]    sramKeep
);

	localparam int unsigned NP = ocpc_pkg::NUM_PERIPH;
	localparam int unsigned NW = ocpc_pkg::NUM_WAKE;

	// all block state in one struct
	typedef struct packed {
		ocpc_pkg::ocpc_pll_type pll;	// pll sequencer
		logic [9:0]  pllCnt;	// sequencer wait counter
		logic [5:0]  divCore;	// post divider counters
		logic [5:0]  divDll;
		logic [5:0]  divTimer;
		logic [5:0]  divEth;
		logic        coreT;
		logic        dllT;
		logic        timerT;
		logic        ethT;
		logic [2:0]  lockSync;	// lock pin sampler
		logic [NW-1:0] wk1;	// wake synchroniser stages
		logic [NW-1:0] wk2;
		logic [NW-1:0] wk3;
		logic [NW-1:0] wkStable;	// filtered wake levels
		logic [NW*4-1:0] wkCnt;	// filter counters
		logic [NW-1:0] wkRec;	// sticky wake record
		ocpc_pkg::ocpc_cg_type aonCg;	// always-on gate machine
		ocpc_pkg::ocpc_cg_type funcCg;	// gated-side gate machine
		logic [3:0]  cgCnt;
		logic [NP-1:0] rst;	// soft resets out
		logic [ocpc_pkg::SRAM_BANKS-1:0] sram;	// sram bank power
	} ocpc_state_type;

	ocpc_state_type state;
	ocpc_state_type next_state;

	// per-peripheral resolved gate request
	logic [NP-1:0] gateReq;
	logic [NP-1:0] rstReq;
	logic          anyWake;
	logic [NP-1:0] cellTick;

	// ownership decode; codes other than subsystem or host mean unowned
	always_comb begin
		for (int p = 0; p < NP; p++) begin
			logic [2:0] own;
			own = ownership[3*p +: 3];
			gateReq[p] = 1'b0;
			rstReq[p]  = 1'b0;
			if (own == ocpc_pkg::OWN_SUBSYS) begin
				gateReq[p] = localClkEn[p];
				rstReq[p]  = localRstEn[p];
			end else if (own == ocpc_pkg::OWN_HOST) begin
				gateReq[p] = hostClkEn[p];
				rstReq[p]  = hostRstEn[p];
			end
			// peripherals lose their clock while the functional domain is gated
			gateReq[p] = gateReq[p] & (state.funcCg == ocpc_pkg::CG_RUN);
		end
	end

	// one glitch-free gate per peripheral, on the timer rate
	generate
		for (genvar g = 0; g < NP; g++) begin : gen_gate
			ocpc_gate_cell u_cell (
				.sys_clk   (sys_clk),
				.rstn      (rstn),
				.rateTick  (state.timerT),
				.gateReq   (gateReq[g]),
				.gatedTick (cellTick[g]),
				.gateOn    (periphClkOn[g])
			);
		end
	endgenerate

	assign periphTick = cellTick;
	assign anyWake    = |state.wkStable;

	// next-state logic
	always_comb begin
		next_state = state;

		// post dividers; each runs only once the pll is up
		next_state.coreT  = 1'b0;
		next_state.dllT   = 1'b0;
		next_state.timerT = 1'b0;
		next_state.ethT   = 1'b0;
		if (state.pll == ocpc_pkg::PLL_RUN) begin
			next_state.divCore  = state.divCore + 6'h01;
			next_state.divDll   = state.divDll + 6'h01;
			next_state.divTimer = state.divTimer + 6'h01;
			next_state.divEth   = state.divEth + 6'h01;
			if (state.divCore == ocpc_pkg::DIV_CORE - 6'h01) begin
				next_state.divCore = 6'h00;
				next_state.coreT   = 1'b1;
			end
			if (state.divDll == ocpc_pkg::DIV_DLL - 6'h01) begin
				next_state.divDll = 6'h00;
				next_state.dllT   = 1'b1;
			end
			if (state.divTimer == ocpc_pkg::DIV_TIMER - 6'h01) begin
				next_state.divTimer = 6'h00;
				next_state.timerT   = 1'b1;
			end
			if (state.divEth == ocpc_pkg::DIV_ETH - 6'h01) begin
				next_state.divEth = 6'h00;
				next_state.ethT   = 1'b1;
			end
		end

		// lock pin crosses in from the pll; only stages two and three compared
		next_state.lockSync = {state.lockSync[1:0], pllLockPin};

		// pll power-up sequence, started by firmware
		case (state.pll)
			ocpc_pkg::PLL_OFF: begin
				next_state.pllCnt = 10'h000;
				if (pllStart) begin
					next_state.pll = ocpc_pkg::PLL_POWER;
				end
			end
			ocpc_pkg::PLL_POWER: begin	// supply rail settles first
				next_state.pllCnt = state.pllCnt + 10'h001;
				if (state.pllCnt == ocpc_pkg::PLL_PWR_SETTLE_CYC - 10'h001) begin
					next_state.pllCnt = 10'h000;
					next_state.pll    = ocpc_pkg::PLL_LOCK;
				end
			end
			ocpc_pkg::PLL_LOCK: begin
				next_state.pllCnt = state.pllCnt + 10'h001;
				if (state.lockSync[2] & state.lockSync[1]) begin
					next_state.pll = ocpc_pkg::PLL_RUN;
				end else if (state.pllCnt == ocpc_pkg::PLL_LOCK_WAIT_CYC) begin
					next_state.pll = ocpc_pkg::PLL_OFF;	// no lock: retry on start
				end
			end
			ocpc_pkg::PLL_RUN: begin
				if (!pllStart) begin
					next_state.pll = ocpc_pkg::PLL_OFF;
				end
			end
			default: begin
				next_state.pll = ocpc_pkg::PLL_OFF;
			end
		endcase

		// wake synchronisers and glitch filters
		next_state.wk1 = wakePin;
		next_state.wk2 = state.wk1;
		next_state.wk3 = state.wk2;
		for (int w = 0; w < NW; w++) begin
			if (state.wk2[w] != state.wk3[w] || state.wk3[w] == state.wkStable[w]) begin
				next_state.wkCnt[4*w +: 4] = 4'h0;	// bounce restarts the filter
			end else if (state.wkCnt[4*w +: 4] == ocpc_pkg::WAKE_FILT_CYC - 4'h1) begin
				next_state.wkCnt[4*w +: 4] = 4'h0;
				next_state.wkStable[w]     = state.wk3[w];
			end else begin
				next_state.wkCnt[4*w +: 4] = state.wkCnt[4*w +: 4] + 4'h1;
			end
			// record: a new wake wins over a clear in the same cycle
			if (wakeClear[w]) begin
				next_state.wkRec[w] = 1'b0;
			end
			if (state.wkStable[w]) begin
				next_state.wkRec[w] = 1'b1;
			end
		end

		// always-on clock-gate machine
		case (state.aonCg)
			ocpc_pkg::CG_RUN: begin
				if (idleReq && powerState == ocpc_pkg::PST_DEEP && !anyWake) begin
					next_state.aonCg = ocpc_pkg::CG_DRAIN;
				end
			end
			ocpc_pkg::CG_DRAIN: begin	// a dropped idle request must not strand it
				if (anyWake || !idleReq) begin
					next_state.aonCg = ocpc_pkg::CG_RUN;
				end else if (state.funcCg == ocpc_pkg::CG_GATED) begin
					next_state.aonCg = ocpc_pkg::CG_GATED;
				end
			end
			ocpc_pkg::CG_GATED: begin
				if (anyWake || !idleReq) begin
					next_state.aonCg = ocpc_pkg::CG_RUN;
				end
			end
			default: begin
				next_state.aonCg = ocpc_pkg::CG_RUN;
			end
		endcase

		// gated-side functional clock-gate machine
		case (state.funcCg)
			ocpc_pkg::CG_RUN: begin
				next_state.cgCnt = 4'h0;
				if (idleReq && powerState != ocpc_pkg::PST_ACTIVE && !anyWake) begin
					next_state.funcCg = ocpc_pkg::CG_DRAIN;
				end
			end
			ocpc_pkg::CG_DRAIN: begin	// let peripherals go quiet first
				next_state.cgCnt = state.cgCnt + 4'h1;
				if (anyWake || !idleReq) begin
					next_state.funcCg = ocpc_pkg::CG_RUN;
				end else if (state.cgCnt == ocpc_pkg::GATE_IDLE_CYC - 4'h1) begin
					next_state.funcCg = ocpc_pkg::CG_GATED;
				end
			end
			ocpc_pkg::CG_GATED: begin
				if (anyWake || !idleReq) begin
					next_state.funcCg = ocpc_pkg::CG_RUN;
				end
			end
			default: begin
				next_state.funcCg = ocpc_pkg::CG_RUN;
			end
		endcase

		// soft resets follow ownership; unowned peripherals stay in reset
		next_state.rst = rstReq;
		for (int p = 0; p < NP; p++) begin
			if (ownership[3*p +: 3] != ocpc_pkg::OWN_SUBSYS &&
			    ownership[3*p +: 3] != ocpc_pkg::OWN_HOST) begin
				next_state.rst[p] = 1'b1;
			end
		end

		// sram power gate machine: light idles keep all banks on
		for (int b = 0; b < ocpc_pkg::SRAM_BANKS; b++) begin
			if (state.funcCg == ocpc_pkg::CG_GATED && powerState == ocpc_pkg::PST_DEEP) begin
				next_state.sram[b] = sramKeep[b];	// per-bank gating
			end else begin
				next_state.sram[b] = 1'b1;
			end
		end
	end

	// register the whole state
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state        <= '0;
			state.pll    <= ocpc_pkg::PLL_OFF;
			state.aonCg  <= ocpc_pkg::CG_RUN;
			state.funcCg <= ocpc_pkg::CG_RUN;
			state.rst    <= '1;
			state.sram   <= '1;
		end else begin
			state <= next_state;
		end
	end

	// outputs, all from flip-flops except the constant pllMult
	assign pllSupplyEn = state.pll != ocpc_pkg::PLL_OFF;
	assign pllEnable   = state.pll[2] | state.pll[3];
	assign pllMult     = ocpc_pkg::PLL_MULT;
	assign pllReady    = state.pll[3];
	assign coreTick    = state.coreT;
	assign dllTick     = state.dllT;
	assign timerTick   = state.timerT;
	assign ethTick     = state.ethT;
	assign periphRst   = state.rst;
	assign wakeRecord  = state.wkRec;
	assign funcClkOn   = state.funcCg != ocpc_pkg::CG_GATED;
	assign aonClkOn    = state.aonCg != ocpc_pkg::CG_GATED;
	assign sramBankOn  = state.sram;

endmodule : ocpc_ctrl

// ==== ocpc_pkg.sv ====
/*
 * ocpc_pkg: constants and types for the ownership clock/power control block.
 * Assumes a single 25 MHz system clock; the divided clock rates are modelled as
 * one-cycle enable pulses derived from it.
 */
package ocpc_pkg;

	// peripheral count and ownership encoding
	localparam int unsigned NUM_PERIPH = 8;
	localparam logic [2:0] OWN_SUBSYS = 3'h0;	// subsystem processor owns
	localparam logic [2:0] OWN_HOST   = 3'h1;	// host processor owns

	// sram layout
	localparam int unsigned SRAM_BANK_KB = 32;
	localparam int unsigned SRAM_TOTAL_KB = 1024;
	localparam int unsigned SRAM_BANKS = SRAM_TOTAL_KB / SRAM_BANK_KB;

	// clock plan, in MHz and kHz
	localparam int unsigned PLL_OUT_MHZ  = 6000;
	localparam int unsigned REF_XTAL_KHZ = 38400;
	localparam int unsigned CORE_MHZ     = 500;
	localparam int unsigned DLL_MHZ      = 400;
	localparam int unsigned TIMER_MHZ    = 200;
	localparam int unsigned ETH_MHZ      = 125;
	localparam int unsigned SYS_MHZ      = 25;

	// post divider ratios from the pll output
	localparam logic [5:0] DIV_CORE  = 6'(PLL_OUT_MHZ / CORE_MHZ);
	localparam logic [5:0] DIV_DLL   = 6'(PLL_OUT_MHZ / DLL_MHZ);
	localparam logic [5:0] DIV_TIMER = 6'(PLL_OUT_MHZ / TIMER_MHZ);
	localparam logic [5:0] DIV_ETH   = 6'(PLL_OUT_MHZ / ETH_MHZ);
	localparam logic [7:0] PLL_MULT  = 8'((PLL_OUT_MHZ * 1000) / REF_XTAL_KHZ);

	// pll power-up sequencing times
	localparam int unsigned PLL_PWR_SETTLE_NS = 1000;
	localparam int unsigned PLL_LOCK_WAIT_NS  = 20000;
	localparam int unsigned SYS_PERIOD_NS     = 1000 / SYS_MHZ;
	localparam logic [9:0] PLL_PWR_SETTLE_CYC =
		10'((PLL_PWR_SETTLE_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);
	localparam logic [9:0] PLL_LOCK_WAIT_CYC =
		10'(PLL_LOCK_WAIT_NS / SYS_PERIOD_NS);

	// wake glitch filter length
	localparam int unsigned NUM_WAKE   = 4;
	localparam logic [3:0] WAKE_FILT_CYC = 4'h8;

	// clock-gate machine idle delay before gating
	localparam logic [3:0] GATE_IDLE_CYC = 4'h4;

	// power states
	typedef enum logic [1:0] {
		PST_ACTIVE = 2'h0,
		PST_LIGHT  = 2'h1,
		PST_ALT    = 2'h2,
		PST_DEEP   = 2'h3
	} ocpc_pstate_type;

	// pll sequencer states, one-hot
	typedef enum logic [3:0] {
		PLL_OFF    = 4'h1,
		PLL_POWER  = 4'h2,
		PLL_LOCK   = 4'h4,
		PLL_RUN    = 4'h8
	} ocpc_pll_type;

	// clock-gate machine states, one-hot
	typedef enum logic [2:0] {
		CG_RUN   = 3'h1,
		CG_DRAIN = 3'h2,
		CG_GATED = 3'h4
	} ocpc_cg_type;

endpackage : ocpc_pkg

// ==== ocpc_gate_cell.sv ====
/*
 * ocpc_gate_cell: glitch-free clock enable for one peripheral.
 * Assumes the enable request comes from logic on the same clock; the cell
 * only changes its gate while the divided clock enable pulse is low.
 */
`timescale 1ns/1ns

module ocpc_gate_cell (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rstn,
	// divided rate pulse of the peripheral's clock
	input  wire logic rateTick,
	// requested gate state
	input  wire logic gateReq,
	// gated clock pulse and gate state
	output logic      gatedTick,
	output logic      gateOn
);

	typedef struct packed {
		logic on;	// gate currently open
		logic tick;	// gated pulse
	} ocpc_cell_type;

	ocpc_cell_type state;
	ocpc_cell_type next_state;

	// gate moves only between pulses, so no pulse is ever cut short
	always_comb begin
		next_state = state;
		if (!rateTick) begin
			next_state.on = gateReq;
		end
		next_state.tick = rateTick & state.on;
	end

	// register
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign gatedTick = state.tick;
	assign gateOn    = state.on;

endmodule : ocpc_gate_cell

// ==== ocpc_ctrl_asserts.sv ====
/* ocpc_ctrl_asserts: port-level checks for ocpc_ctrl.
 * assumes one clock sys_clk and async active-low rstn; bound below. */
`timescale 1ns/1ns

module ocpc_ctrl_asserts (
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        rstn,
	// pll
	input wire logic        pllStart,
	input wire logic        pllSupplyEn,
	input wire logic        pllEnable,
	input wire logic [7:0]  pllMult,
	input wire logic        pllReady,
	input wire logic        coreTick,
	input wire logic        timerTick,
	// gating
	input wire logic [23:0] ownership,
	input wire logic [7:0]  localRstEn,
	input wire logic [7:0]  periphClkOn,
	input wire logic [7:0]  periphRst,
	// power and wakes
	input wire logic [1:0]  powerState,
	input wire logic [3:0]  wakePin,
	input wire logic [3:0]  wakeRecord,
	input wire logic        funcClkOn,
	input wire logic [31:0] sramBankOn,
	input wire logic [31:0] sramKeep
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	// 6 GHz over a 38.4 MHz reference
	AST_MULT: assert property (pllMult == 8'h9C)
		else $error("pll multiplier wrong");
	// start taken in off state
	AST_SUPPLY: assert property (pllStart && !pllSupplyEn |=> pllSupplyEn)
		else $error("pll supply not raised");
	// settle count of the power step
	AST_SETTLE: assert property ($rose(pllSupplyEn) |-> ##24 !pllEnable ##1 pllEnable)
		else $error("pll enable timing wrong");
	AST_READY: assert property (pllReady |-> pllEnable && pllSupplyEn)
		else $error("pll ready without enable");
	// core rate keeps its period while running
	AST_CORE: assert property (coreTick |-> ##12 (coreTick || !pllReady))
		else $error("core tick period wrong");
	// two cycles allow one frozen tick cycle
	AST_UNOWNED: assert property ($past(ownership[2:1], 2) != 2'h0 &&
		$past(ownership[2:1]) != 2'h0 |-> !periphClkOn[0] && periphRst[0])
		else $error("unowned peripheral not held");
	// first edge after reset still shows the reset value, so skip it
	AST_RST: assert property ($past(rstn) && $past(ownership[2:0]) == 3'h0 |->
		periphRst[0] == $past(localRstEn[0]))
		else $error("soft reset source wrong");
	AST_FUNC: assert property (!funcClkOn |-> periphClkOn == 8'h00)
		else $error("gate open while gated");
	// no gate edge inside a tick cycle
	AST_FREEZE: assert property (timerTick |=> $stable(periphClkOn))
		else $error("gate moved during tick");
	AST_WAKE: assert property ($rose(wakeRecord[0]) |->
		$past(wakePin[0], 5) && $past(wakePin[0], 10))
		else $error("wake recorded without filter");
	AST_SRAM: assert property (!funcClkOn && $past(!funcClkOn) && powerState == 2'h3 &&
		$past(powerState) == 2'h3 && $stable(sramKeep) |-> sramBankOn == sramKeep)
		else $error("sram banks not per keep");
	AST_SRAM_ON: assert property (funcClkOn && $past(funcClkOn) |-> &sramBankOn)
		else $error("sram bank off while running");

	COV_READY: cover property ($rose(pllReady));
	COV_GATED: cover property ($fell(funcClkOn));
	COV_WAKE: cover property ($rose(wakeRecord[0]));
endmodule : ocpc_ctrl_asserts

bind ocpc_ctrl ocpc_ctrl_asserts u_chk (.*);

// ==== ocpc_periph_model.sv ====
/* ocpc_periph_model: peripherals fed by the gated ticks.
 * assumes clrCnt pulsed before use; counts start unknown. */
`timescale 1ns/1ns

module ocpc_periph_model (
	// clock and count clear
	input wire logic        sys_clk,
	input wire logic        clrCnt,
	// gated ticks and soft resets
	input wire logic [7:0]  periphTick,
	input wire logic [7:0]  periphRst,
	// one byte of tick count per peripheral
	output logic [63:0]     tickCnt
);
	// a peripheral in soft reset loses its count
	always @(posedge sys_clk) begin
		for (int p = 0; p < 8; p++) begin
			if (clrCnt || periphRst[p])
				tickCnt[8*p+:8] <= 8'h00;
			else if (periphTick[p])
				tickCnt[8*p+:8] <= tickCnt[8*p+:8] + 8'h01;
		end
	end
endmodule : ocpc_periph_model

// ==== tb_top.sv ====
/* tb_top: self-checking bench for ocpc_ctrl.
 * assumes the checker binds itself; peripherals modelled separately. */
`timescale 1ns/1ns

module tb_top;
	// stimulus
	logic        sys_clk = 1'b0;
	logic        rstn = 1'b0;
	logic        pllStart = 1'b0, pllLockPin = 1'b0, idleReq = 1'b0, clrCnt = 1'b0;
	logic [23:0] ownership = 24'h0;
	logic [7:0]  localClkEn = 8'h00, hostClkEn = 8'h00, localRstEn = 8'h00, hostRstEn = 8'h00;
	logic [1:0]  powerState = 2'h0;
	logic [3:0]  wakePin = 4'h0, wakeClear = 4'h0;
	logic [31:0] sramKeep = 32'h0;
	// design outputs
	logic        pllSupplyEn, pllEnable, pllReady, coreTick, dllTick, timerTick, ethTick;
	logic        funcClkOn, aonClkOn;
	logic [7:0]  pllMult, periphClkOn, periphTick, periphRst;
	logic [3:0]  wakeRecord;
	logic [31:0] sramBankOn;
	logic [63:0] tickCnt;
	// notes: {ready, func clock, wake record, soft resets, gates}
	logic [21:0] expQ[$];
	logic [21:0] cur, obs, prev = 'x;
	int          n_mismatch = 0, num_checks = 0;

	always #20 sys_clk = ~sys_clk;

	ocpc_ctrl DUT (.*);
	ocpc_periph_model u_periph (.*);

	task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp

	task automatic conclude();
		if (n_mismatch == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude

	// only a real change is queued, so each note matches one event
	task automatic note(input logic [21:0] v);
		if (v !== cur)
			expQ.push_back(v);
		cur = v;
	endtask : note

	// bounded wait for outstanding notes
	task automatic drain(input int lim);
		for (int i = 0; i < lim && expQ.size() != 0; i++)
			@(negedge sys_clk);
		if (expQ.size() != 0) begin
			n_mismatch++;
			conclude();
		end
		repeat (4) @(negedge sys_clk);
	endtask : drain

	// owner picks the enable source; unowned stays gated in reset
	function automatic logic [15:0] expGate();
		logic [15:0] r;
		logic [2:0]  o;
		for (int p = 0; p < 8; p++) begin
			o = ownership[3*p+:3];
			r[p] = o == 3'h0 ? localClkEn[p] : (o == 3'h1 && hostClkEn[p]);
			r[p+8] = o == 3'h0 ? localRstEn[p] : (o != 3'h1 || hostRstEn[p]);
		end
		return r;
	endfunction : expGate

	// watcher: every change of the observed outputs takes one note
	always @(negedge sys_clk) begin
		obs = {pllReady, funcClkOn, wakeRecord, periphRst, periphClkOn};
		if (obs !== prev) begin
			prev = obs;
			if (expQ.size() == 0)
				cmp(obs, 'x);
			else
				cmp(obs, expQ.pop_front());
		end
	end

	initial begin
		int          c;
		logic [31:0] tc;
		void'($urandom(32'h5C8E));
		cur = 'x;
		note({2'h1, 4'h0, 8'hFF, 8'h00});
		repeat (5) @(posedge sys_clk);
		@(negedge sys_clk);
		rstn = 1'b1;
		note({cur[21:16], 16'h0});
		drain(20);
		// every ownership code on every peripheral, random enables
		for (int i = 0; i < 8; i++) begin
			for (int p = 0; p < 8; p++)
				ownership[3*p+:3] = 3'(i + p);
			{localClkEn, hostClkEn, localRstEn, hostRstEn} = $urandom;
			note({cur[21:16], expGate()});
			drain(10);
		end
		ownership = 24'h0;
		{localClkEn, localRstEn} = 16'h0;
		note({cur[21:16], 16'h0});
		drain(10);
		// short glitch is dropped, long wake recorded
		wakePin[1] = 1'b1;
		repeat (6) @(negedge sys_clk);
		wakePin = 4'h1;
		note({cur[21:20], 4'h1, cur[15:0]});
		drain(30);
		wakeClear = 4'h1;
		@(negedge sys_clk);
		wakeClear = 4'h0;
		wakePin = 4'h0;
		repeat (16) @(negedge sys_clk);
		wakeClear = 4'h1;
		@(negedge sys_clk);
		wakeClear = 4'h0;
		note({cur[21:20], 4'h0, cur[15:0]});
		drain(10);
		// idle in each power state; open gates close before the domain gates
		sramKeep = $urandom;
		localClkEn = 8'h0F;
		note({cur[21:8], 8'h0F});
		drain(10);
		for (int s = 3; s >= 0; s--) begin
			powerState = 2'(s);
			idleReq = 1'b1;
			if (s != 0)
				note({cur[21:8], 8'h00});
			note({cur[21], s == 0, cur[19:0]});
			drain(20);
			cmp(sramBankOn, s == 3 ? sramKeep : 32'hFFFFFFFF);
			cmp(aonClkOn, s != 3);
			idleReq = 1'b0;
			note({cur[21], 1'b1, cur[19:0]});
			note({cur[21:8], 8'h0F});
			drain(20);
		end
		// pll start, lock and rates
		cmp(pllMult, 8'h9C);
		pllStart = 1'b1;
		for (c = 0; c < 40 && !pllEnable; c++)
			@(negedge sys_clk);
		cmp(c, 26);
		cmp(pllSupplyEn, 1'b1);
		pllLockPin = 1'b1;
		note({1'b1, cur[20:0]});
		drain(20);
		localClkEn = 8'hA5;
		note({cur[21:8], 8'hA5});
		drain(10);
		clrCnt = 1'b1;
		@(negedge sys_clk);
		clrCnt = 1'b0;
		tc = 32'h0;
		repeat (240) begin
			tc = tc + {7'h0, coreTick, 7'h0, dllTick, 7'h0, timerTick, 7'h0, ethTick};
			@(negedge sys_clk);
		end
		cmp(tc, 32'h14100805);
		cmp(tickCnt, 64'h0800080000080008);
		pllStart = 1'b0;
		note({1'b0, cur[20:0]});
		drain(10);
		// lock never comes: sequencer gives up
		pllLockPin = 1'b0;
		pllStart = 1'b1;
		for (c = 0; c < 40 && !pllEnable; c++)
			@(negedge sys_clk);
		cmp(c, 26);
		for (c = 0; c < 700 && pllEnable; c++)
			@(negedge sys_clk);
		pllStart = 1'b0;
		cmp(c, 501);
		cmp(pllSupplyEn, 1'b0);
		conclude();
	end
endmodule : tb_top
